// ===== dv/pcpc_board.sv
module pcpc_board (
    input wire logic [31:0] pin_out_i,
    input wire logic [31:0] pin_oe_i,
    input wire logic [31:0] ext_en_i,
    input wire logic [31:0] ext_val_i,
    output logic [31:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // Pull-up on every pin, so a released line never keeps its last value
    assign pin_lvl_o = (pin_oe_i & pin_out_i)
        | (~pin_oe_i & ~(ext_en_i & ~ext_val_i));
endmodule

// ===== dv/port_crossbar_pin_control_test.sv
module port_crossbar_pin_control_test
    import pcpc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready;
    logic hresp;
    logic [31:0] hrdata_q;
    logic [31:0] pin_lvl;
    logic [31:0] pin_out;
    logic [31:0] pin_oe;
    logic [31:0] periph_out = 32'h0;
    logic [31:0] periph_in;
    logic xbar_en;
    logic [31:0] ext_en = 32'h0;
    logic [31:0] ext_val = 32'h0;
    int err_count = 0;
    int checks_done = 0;

    pcpc_port_ctrl dut (
        .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .pin_in_i(pin_lvl), .pin_out_o(pin_out), .pin_oe_o(pin_oe),
        .periph_out_i(periph_out), .periph_in_o(periph_in),
        .xbar_enabled_o(xbar_en)
    );
    pcpc_board board (
        .pin_out_i(pin_out), .pin_oe_i(pin_oe), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pin_lvl_o(pin_lvl)
    );

    initial begin
        forever #50 clk_sys_i = ~clk_sys_i;
    end

    // Read data as it stood just before each edge; it clears at the edge
    always @(posedge clk_sys_i) begin
        hrdata_q <= hrdata;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask

    // Bounded, so a stuck slave ends the run instead of hanging it
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (hready !== 1'b1 && n < 20);
        if (hready !== 1'b1) begin
            err_count++;
            end_of_test();
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_i);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, a};
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        #1;
        rd = hrdata_q;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, a, d, v);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        bus(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask

    // Pins follow a register write one edge later
    task automatic settle();
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic side(input logic [31:0] en, input logic [31:0] val,
                        input logic [31:0] per);
        @(posedge clk_sys_i);
        ext_en <= en;
        ext_val <= val;
        periph_out <= per;
    endtask

    task automatic t_reset();
        rdchk(ADDR_MODE, 32'h00000000);
        rdchk(ADDR_DATA_RMW, 32'hFFFFFFFF);
        rdchk(ADDR_DATA, 32'hFFFFFFFF);
        check(pin_oe, 32'h00000000);
        check({31'h0, hresp}, 32'h00000000);
        check({31'h0, xbar_en}, 32'h00000000);
    endtask

    task automatic t_disabled();
        side(32'h000000FF, 32'h0000005A, 32'h0);
        wr(ADDR_DATA, 32'h00000000);
        wr(ADDR_MODE, 32'hFFFFFFFF);
        settle();
        check(pin_oe, 32'h00000000);
        rdchk(ADDR_DATA, 32'hFFFFFF5A);
        rdchk(ADDR_DATA_RMW, 32'h00000000);
        side(32'h0, 32'h0, 32'h0);
    endtask

    task automatic t_pushpull();
        wr(ADDR_PERIPH_SEL, 32'h00000000);
        wr(ADDR_CTRL, 32'h00000010);
        wr(ADDR_DATA, 32'h00FFA5C3);
        settle();
        check({31'h0, xbar_en}, 32'h00000001);
        rdchk(ADDR_CTRL, 32'h00000010);
        check(pin_oe, 32'hFFFFFFFF);
        check(pin_out, 32'h00FFA5C3);
        rdchk(ADDR_DATA, 32'h00FFA5C3);
    endtask

    task automatic t_opendrain();
        wr(ADDR_MODE, 32'h0000FFFF);
        side(32'h00FF0000, 32'h0, 32'h0);
        settle();
        check(pin_oe, 32'hFF00FFFF);
        check(pin_out & pin_oe, 32'h0000A5C3);
        rdchk(ADDR_DATA, 32'h0000A5C3);
        rdchk(ADDR_DATA_RMW, 32'h00FFA5C3);
        side(32'h0, 32'h0, 32'h0);
    endtask

    task automatic t_periph();
        side(32'h0, 32'h0, 32'h0000000A);
        wr(ADDR_PERIPH_SEL, 32'h0000000F);
        wr(ADDR_DATA, 32'h00FFA5C0);
        settle();
        check(pin_out & 32'hF, 32'h0000000A);
        check(pin_oe & 32'hF, 32'h0000000F);
        wr(ADDR_MODE, 32'h0000FFF0);
        settle();
        check(pin_oe & 32'hF, 32'h00000005);
        side(32'h00000100, 32'h0, 32'h0000000A);
        wr(ADDR_PERIPH_IN, 32'h00000100);
        settle();
        check(pin_oe & 32'h100, 32'h00000000);
        check(periph_in & 32'h100, 32'h00000000);
    endtask

    task automatic t_forced();
        side(32'h0, 32'h0, 32'h0);
        wr(ADDR_PERIPH_SEL, 32'h0);
        wr(ADDR_PERIPH_IN, 32'h0);
        wr(ADDR_MODE, 32'hFFFFFFFF);
        wr(ADDR_DATA, 32'hFFFFFFFF);
        wr(ADDR_SERIAL_CFG, 32'h0C191405);
        settle();
        check(pin_oe, 32'hFFEFCFFF);
        wr(ADDR_SERIAL_CFG, 32'h0C191407);
        settle();
        check(pin_oe, 32'hFDEFCFFF);
        wr(ADDR_FORCE_OD, 32'h00000001);
        settle();
        check(pin_oe, 32'hFDEFCFFE);
        rdchk(ADDR_FORCE_OD, 32'h00000001);
    endtask

    task automatic t_unmapped();
        wr(8'h20, 32'h12345678);
        rdchk(8'h20, 32'h00000000);
        rdchk(ADDR_DATA_RMW, 32'hFFFFFFFF);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_i);
        arst_n_i <= 1'b1;
        t_reset();
        t_disabled();
        t_pushpull();
        t_opendrain();
        t_periph();
        t_forced();
        t_unmapped();
        end_of_test();
    end
endmodule

// ===== src/pcpc_pkg.sv
package pcpc_pkg;
    localparam int NPORT = 4;
    localparam int NPIN = 32;
    // Byte addresses of the register words
    localparam logic [7:0] ADDR_DATA = 8'h00;
    localparam logic [7:0] ADDR_DATA_RMW = 8'h04;
    localparam logic [7:0] ADDR_MODE = 8'h08;
    localparam logic [7:0] ADDR_CTRL = 8'h0C;
    localparam logic [7:0] ADDR_PERIPH_SEL = 8'h10;
    localparam logic [7:0] ADDR_PERIPH_IN = 8'h14;
    localparam logic [7:0] ADDR_FORCE_OD = 8'h18;
    localparam logic [7:0] ADDR_SERIAL_CFG = 8'h1C;
    // Fields of the control word
    localparam int CTRL_XBAR_EN_BIT = 4;
    // Fields of the serial/two-wire config word
    localparam int SCFG_S0_MODE0_BIT = 0;
    localparam int SCFG_S1_MODE0_BIT = 1;
    localparam int SCFG_TW_EN_BIT = 2;
    localparam int PIN_IDX_W = 5;
    localparam int SCFG_S0_RX_LSB = 8;
    localparam int SCFG_S1_RX_LSB = 16;
    localparam int SCFG_SDA_LSB = 24;
    // Reset values
    localparam logic [31:0] RST_DATA = 32'hFFFFFFFF;
    localparam logic [31:0] RST_MODE = 32'h00000000;
    localparam logic [31:0] RST_ZERO = 32'h00000000;
    // Bus encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ = 2'h3;
endpackage

// ===== src/pcpc_port_ctrl.sv
module pcpc_port_ctrl
    import pcpc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [31:0] pin_in_i,
    output logic [31:0] pin_out_o,
    output logic [31:0] pin_oe_o,
    input wire logic [31:0] periph_out_i,
    output logic [31:0] periph_in_o,
    output logic xbar_enabled_o
);
    logic [31:0] data_latch;
    logic [31:0] mode;
    logic xbar_en;
    logic [31:0] periph_sel;
    logic [31:0] periph_in;
    logic [31:0] force_od;
    logic [31:0] serial_cfg;
    logic [31:0] pin_sync;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_pend;
    logic [7:0] rd_addr;
    logic [31:0] od_mask;
    logic [31:0] drv_val;
    logic [31:0] next_pin_out;
    logic [31:0] next_pin_oe;
    logic [31:0] rd_val;
    logic req;

    // One-hot mask for a pin index
    function automatic logic [31:0] pin_bit(input logic [PIN_IDX_W-1:0] idx);
        pin_bit = 32'h00000001 << idx;
    endfunction

    assign req = hsel_i && hready_i && htrans_i[1];

    // Address phase capture; zero-wait data phase
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            wr_addr <= 8'h00;
            rd_addr <= 8'h00;
        end else begin
            wr_pend <= req && hwrite_i;
            rd_pend <= req && !hwrite_i;
            if (req) begin
                wr_addr <= {haddr_i[7:2], 2'h0};
                rd_addr <= {haddr_i[7:2], 2'h0};
            end
        end
    end

    // Register writes
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            data_latch <= RST_DATA;
            mode <= RST_MODE;
            xbar_en <= 1'b0;
            periph_sel <= RST_ZERO;
            periph_in <= RST_ZERO;
            force_od <= RST_ZERO;
            serial_cfg <= RST_ZERO;
        end else if (wr_pend) begin
            unique case (wr_addr)
                ADDR_DATA, ADDR_DATA_RMW: data_latch <= hwdata_i;
                ADDR_MODE: mode <= hwdata_i;
                ADDR_CTRL: xbar_en <= hwdata_i[CTRL_XBAR_EN_BIT];
                ADDR_PERIPH_SEL: periph_sel <= hwdata_i;
                ADDR_PERIPH_IN: periph_in <= hwdata_i;
                ADDR_FORCE_OD: force_od <= hwdata_i;
                ADDR_SERIAL_CFG: serial_cfg <= hwdata_i;
                default: ;
            endcase
        end
    end

    // Pins are taken as synchronous; one stage keeps reads registered
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_sync <= RST_DATA;
        end else begin
            pin_sync <= pin_in_i;
        end
    end

    // Pins forced to open-drain by the force mask, two-wire and mode-0 receive
    always_comb begin
        od_mask = force_od;
        if (serial_cfg[SCFG_S0_MODE0_BIT]) begin
            od_mask = od_mask | pin_bit(serial_cfg[SCFG_S0_RX_LSB +: PIN_IDX_W]);
        end
        if (serial_cfg[SCFG_S1_MODE0_BIT]) begin
            od_mask = od_mask | pin_bit(serial_cfg[SCFG_S1_RX_LSB +: PIN_IDX_W]);
        end
        if (serial_cfg[SCFG_TW_EN_BIT]) begin
            od_mask = od_mask | pin_bit(serial_cfg[SCFG_SDA_LSB +: PIN_IDX_W])
                | pin_bit(serial_cfg[SCFG_SDA_LSB +: PIN_IDX_W] + 5'h01);
        end
    end

    // Per-pin driver
    genvar g;
    generate
        for (g = 0; g < NPIN; g++) begin : g_pin
            always_comb begin
                // Peripheral owns the level when routed, else the latch
                drv_val[g] = periph_sel[g] ? periph_out_i[g]
                    : data_latch[g];
                next_pin_out[g] = drv_val[g];
                if (!xbar_en || periph_in[g]) begin
                    next_pin_oe[g] = 1'b0;
                end else if (mode[g] && !od_mask[g]) begin
                    next_pin_oe[g] = 1'b1;
                end else begin
                    next_pin_oe[g] = !drv_val[g];
                end
            end
        end
    endgenerate

    // Pin outputs registered; drive value is meaningless while oe low
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pin_out_o <= RST_DATA;
            pin_oe_o <= RST_ZERO;
            periph_in_o <= RST_DATA;
            xbar_enabled_o <= 1'b0;
        end else begin
            pin_out_o <= next_pin_out;
            pin_oe_o <= next_pin_oe;
            periph_in_o <= pin_in_i;
            xbar_enabled_o <= xbar_en;
        end
    end

    // Read mux
    always_comb begin
        unique case (rd_addr)
            ADDR_DATA: rd_val = pin_sync;
            ADDR_DATA_RMW: rd_val = data_latch;
            ADDR_MODE: rd_val = mode;
            ADDR_CTRL: rd_val = 32'(xbar_en) << CTRL_XBAR_EN_BIT;
            ADDR_PERIPH_SEL: rd_val = periph_sel;
            ADDR_PERIPH_IN: rd_val = periph_in;
            ADDR_FORCE_OD: rd_val = force_od;
            ADDR_SERIAL_CFG: rd_val = serial_cfg;
            default: rd_val = 32'h00000000;
        endcase
    end

    // Read data registered at the address-phase edge, valid in data phase
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            hrdata_o <= 32'h00000000;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end else begin
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            hrdata_o <= 32'h00000000;
            if (req && !hwrite_i) begin
                unique case ({haddr_i[7:2], 2'h0})
                    ADDR_DATA: hrdata_o <= pin_sync;
                    ADDR_DATA_RMW: hrdata_o <= data_latch;
                    default: hrdata_o <= rd_sel(haddr_i[7:0]);
                endcase
            end
        end
    end

    function automatic logic [31:0] rd_sel(input logic [7:0] a);
        unique case ({a[7:2], 2'h0})
            ADDR_MODE: rd_sel = mode;
            ADDR_CTRL: rd_sel = 32'(xbar_en) << CTRL_XBAR_EN_BIT;
            ADDR_PERIPH_SEL: rd_sel = periph_sel;
            ADDR_PERIPH_IN: rd_sel = periph_in;
            ADDR_FORCE_OD: rd_sel = force_od;
            ADDR_SERIAL_CFG: rd_sel = serial_cfg;
            default: rd_sel = 32'h00000000;
        endcase
    endfunction

    logic unused_rd;
    assign unused_rd = ^{rd_val, rd_pend, hsize_i, htrans_i[0]};

    a_xbar_off_no_drive: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        !xbar_en |=> pin_oe_o == 32'h00000000)
        else $error("driver on while crossbar disabled");
    a_input_no_drive: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> (pin_oe_o & $past(periph_in)) == 32'h00000000)
        else $error("driver on for peripheral input");
    a_od_never_high: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> (pin_oe_o & pin_out_o & ~$past(mode)) == 32'h00000000)
        else $error("open-drain pin driven high");
    a_forced_od: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> (pin_oe_o & pin_out_o & $past(od_mask)) == 32'h00000000)
        else $error("forced open-drain pin driven high");
    a_pp_drive: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (xbar_en && periph_in == 32'h0 && od_mask == 32'h0
            && mode == 32'hFFFFFFFF)
        |=> pin_oe_o == 32'hFFFFFFFF)
        else $error("push-pull pin not driven");
    a_periph_follow: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> ((pin_out_o ^ $past(periph_out_i)) & $past(periph_sel))
            == 32'h00000000)
        else $error("peripheral pin not following peripheral");
    a_pin_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:0] == ADDR_DATA)
        |=> hrdata_o == $past(pin_sync))
        else $error("pin read wrong");
    a_rmw_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:0] == ADDR_DATA_RMW)
        |=> hrdata_o == $past(data_latch))
        else $error("latch read wrong");

    a_zero_wait: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> hreadyout_o)
        else $error("slave inserted a wait state");

    a_resp_okay: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> !hresp_o)
        else $error("slave answered with an error");

    a_mode_write: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (wr_pend && wr_addr == ADDR_MODE) |=> mode == $past(hwdata_i))
        else $error("mode write lost");

    a_latch_write: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (wr_pend && (wr_addr == ADDR_DATA || wr_addr == ADDR_DATA_RMW))
        |=> data_latch == $past(hwdata_i))
        else $error("latch write lost");

    a_latch_hold: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        !(wr_pend && (wr_addr == ADDR_DATA || wr_addr == ADDR_DATA_RMW))
        |=> $stable(data_latch))
        else $error("latch changed without a write");

    a_xbar_copy: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> xbar_enabled_o == $past(xbar_en))
        else $error("crossbar enable copy wrong");

    a_gpio_value: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> ((pin_out_o ^ $past(data_latch)) & ~$past(periph_sel))
            == 32'h00000000)
        else $error("pin value not from latch");

    a_low_driven: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        xbar_en |=> (~pin_oe_o & ~$past(periph_in) & ~$past(periph_sel)
            & ~$past(data_latch)) == 32'h00000000)
        else $error("low level not driven");

    a_od_release: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> (pin_oe_o & ~$past(mode) & ~$past(periph_sel)
            & $past(data_latch)) == 32'h00000000)
        else $error("open-drain high not released");

    a_pin_sample: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> pin_sync == $past(pin_in_i))
        else $error("pin sample stage wrong");

    a_periph_in: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        1'b1 |=> periph_in_o == $past(pin_in_i))
        else $error("peripheral input not pin level");

    a_unmapped_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:5] != 3'h0)
        |=> hrdata_o == 32'h00000000)
        else $error("unmapped read not zero");

    a_rdata_idle: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        !(req && !hwrite_i) |=> hrdata_o == 32'h00000000)
        else $error("read data outside data phase");

    a_ctrl_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:0] == ADDR_CTRL)
        |=> hrdata_o == ({31'h00000000, $past(xbar_en)} << CTRL_XBAR_EN_BIT))
        else $error("control read wrong");

    a_mode_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:0] == ADDR_MODE)
        |=> hrdata_o == $past(mode))
        else $error("mode read wrong");

    a_force_read: assert property (@(posedge clk_sys_i)
        disable iff (!arst_n_i)
        (req && !hwrite_i && haddr_i[7:0] == ADDR_FORCE_OD)
        |=> hrdata_o == $past(force_od))
        else $error("force mask read wrong");

    c_enable: cover property (@(posedge clk_sys_i) $rose(xbar_en));
    c_in_pin: cover property (@(posedge clk_sys_i) |(periph_in & ~pin_in_i));
    c_forced: cover property (@(posedge clk_sys_i) |(od_mask & mode));
    c_pp: cover property (@(posedge clk_sys_i) |(pin_oe_o & pin_out_o));
    c_od_low: cover property (@(posedge clk_sys_i) |(pin_oe_o & ~pin_out_o));
endmodule
